// ===== hdl/tvsr_defines.vh
// tvsr_defines.vh: register offsets, field positions, reset values, timing counts
// assumes: included by the measurement readout design files only
`ifndef TVSR_DEFINES_VH
`define TVSR_DEFINES_VH
`define TVSR_ADDR_TEMP_DATA 6'h09
`define TVSR_ADDR_TEMP_CTRL 6'h0A
`define TVSR_ADDR_VOLT_CAPS 6'h10
`define TVSR_ADDR_VOLT_DATA 6'h11
`define TVSR_ADDR_VOLT_CTRL 6'h12
`define TVSR_ADDR_DEV_STATUS 6'h13
`define TVSR_TCTRL_RESET 4'h0
`define TVSR_TCTRL_ATE 0
`define TVSR_VCTRL_ATE 5
`define TVSR_VCTRL_EN_LSB 6
`define TVSR_VCTRL_RO_LOW 5'h1F
`define TVSR_VCAPS_VALUE 16'h0051
`define TVSR_FUNC_TYPE 4'h2
`define TVSR_STAT_SF 0
`define TVSR_STAT_ERF 1
`define TVSR_NUM_INPUTS 5
`define TVSR_SCAN_PERIOD_MS 50
`define TVSR_CLK_KHZ 20000
`define TVSR_SCAN_CYCLES (`TVSR_SCAN_PERIOD_MS * `TVSR_CLK_KHZ)
`define TVSR_LOWPWR_FACTOR 4
`endif

// ===== hdl/tvsr_next_input.v
// tvsr_next_input.v: picks the next enabled voltage input after the current one
// assumes: enable mask and current index come from the same clock domain
module tvsr_next_input (
   input wire [4:0] enables,
   input wire [2:0] current,
   output reg [2:0] next_idx,
   output reg any_enabled
);
   integer k;
   reg [2:0] cand;
   reg [3:0] sum;
   reg found;
   always @* begin
      next_idx = current;
      found = 1'b0;
      cand = 3'h0;
      sum = 4'h0;
      any_enabled = |enables;
      // walk upward from current+1, wrapping at the last input;
      // the sum reaches 9, so it is kept at four bits before the wrap
      for (k = 1; k <= 5; k = k + 1) begin
         sum = {1'b0, current} + k[3:0];
         if (sum >= 4'h5) begin
            sum = sum - 4'h5;
         end
         cand = sum[2:0];
         if (!found && enables[cand]) begin
            next_idx = cand;
            found = 1'b1;
         end
      end
   end
endmodule // tvsr_next_input

// ===== hdl/tvsr_readout.v
// tvsr_readout.v: temperature control, voltage scan, readout, status and capabilities
// assumes: the serial bus engine presents decoded register reads and writes on clk;
// conversion results arrive as a done pulse from the analog front end on clk
`include "tvsr_defines.vh"

// Summary of operation
// RULE1: temperature attention only when its attention enable and a sensor enable are set.
// RULE2: temperature control bits 1..3 enable local, remote one, remote two; reset off.
// RULE3: reset clears temperature control; bits 15-4 read zero.
// RULE4: enabled voltage inputs are measured continuously, scan restarts after last one.
// RULE5: an input is scanned only when its own enable bit is set.
// RULE6: inputs visited in ascending order with wrap; disabled inputs skipped.
// RULE7: scan refreshes each result at least every 250 ms (4 Hz or faster).
// RULE8: low-power mode scans at a quarter of the active rate.
// RULE9: storing a result raises a function event and sets the result flag until cleared.
// RULE10: reading the voltage readout clears the result flag.
// RULE11: a result completing while previous unread overwrites it and sets overrun flag.
// RULE12: reading the voltage readout also clears the overrun flag.
// RULE13: conversions are paced so the master has time to read each result.
// RULE14: voltage event asks attention only when voltage attention enable is set.
// RULE15: every voltage input reports a 9-bit unsigned result.
// RULE16: out-of-range results clamp to all ones or all zeros.
// RULE17: readout resolution is fixed; writes cannot change it.
// RULE18: voltage function type code is 0010.
// RULE19: capability bits 2-0 read 001; value left aligned, zero fill.
// RULE20: capability bit 3 reads 0, readout is 16 bits wide.
// RULE21: capability bits 8-4 read 5; upper bits read zero.
// RULE22: master needs no setup; setting enables alone starts measurement.
// RULE23: temperature results are 10-bit two's complement, half degree per step.
// RULE24: voltage readout holds result in 15-7, input number in 4-2, rest zero.
// RULE25: voltage control bit 5 attention enable, bits 6..10 enable inputs 0..4.
// RULE26: no enabled input means no conversions, no readout change, no events.
module tvsr_readout #(
   parameter SCAN_CYCLES = `TVSR_SCAN_CYCLES
) (
   input wire clk,
   input wire rstn,
   input wire [5:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   input wire low_power,
   input wire conv_done,
   input wire [10:0] conv_raw,
   input wire [1:0] temp_sensor,
   input wire temp_done,
   input wire [9:0] temp_value,
   input wire temp_fault,
   output reg [15:0] reg_rdata_q,
   output reg conv_start_q,
   output reg [2:0] conv_input_q,
   output reg [2:0] temp_enables_q,
   output reg attention_q,
   output reg func_event_q
);
   reg [15:0] tctrl_q;
   reg [15:0] vctrl_q;
   reg [15:0] vdata_q;
   reg [15:0] tdata_q;
   reg sf_q;
   reg erf_q;
   reg busy_q;
   reg [31:0] pace_q;
   reg [2:0] cur_q;
   reg first_q;
   wire [4:0] volt_en;
   wire [2:0] nxt;
   wire any_en;
   wire [31:0] pace_limit;
   wire rd_vdata;
   wire store;
   reg [8:0] clamped;

   // keep result in range: saturate instead of wrapping
   function [8:0] tvsr_clamp;
      input [10:0] raw;
      begin
         if (raw[10]) begin
            tvsr_clamp = 9'h000;
         end else if (raw[9]) begin
            tvsr_clamp = 9'h1FF;
         end else begin
            tvsr_clamp = raw[8:0];
         end
      end
   endfunction

   function is_addr;
      input [5:0] a;
      input [5:0] b;
      begin
         is_addr = (a == b);
      end
   endfunction

   assign volt_en = vctrl_q[`TVSR_VCTRL_EN_LSB +: 5]; // [RULE25]
   assign rd_vdata = reg_rd && is_addr(reg_addr, `TVSR_ADDR_VOLT_DATA);
   assign store = busy_q && conv_done && any_en; // [RULE26]
   // each slot spreads the refresh period across five inputs; low power stretches it
   assign pace_limit = low_power ? (SCAN_CYCLES * `TVSR_LOWPWR_FACTOR) / 5 : SCAN_CYCLES / 5; // [RULE8] [RULE7]

   tvsr_next_input u_next (
      .enables(volt_en),
      .current(cur_q),
      .next_idx(nxt),
      .any_enabled(any_en)
   );

   always @* begin
      clamped = tvsr_clamp(conv_raw); // [RULE16] [RULE15]
   end

   // control registers
   always @(posedge clk) begin
      if (!rstn) begin
         tctrl_q <= 16'h0000; // [RULE3]
         vctrl_q <= {11'h000, `TVSR_VCTRL_RO_LOW};
      end else if (reg_wr) begin
         if (is_addr(reg_addr, `TVSR_ADDR_TEMP_CTRL)) begin
            tctrl_q <= {12'h000, reg_wdata[3:0]}; // [RULE2] [RULE3]
         end
         if (is_addr(reg_addr, `TVSR_ADDR_VOLT_CTRL)) begin
            vctrl_q <= {5'h00, reg_wdata[10:5], `TVSR_VCTRL_RO_LOW}; // [RULE25]
         end
      end
   end

   // scan sequencer: one conversion per paced slot, never while idle
   always @(posedge clk) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         pace_q <= 32'h00000000;
         cur_q <= 3'h4;
         first_q <= 1'b1;
         conv_start_q <= 1'b0;
         conv_input_q <= 3'h0;
      end else begin
         conv_start_q <= 1'b0;
         if (!any_en) begin
            busy_q <= 1'b0; // [RULE26]
            pace_q <= 32'h00000000;
            first_q <= 1'b1;
            cur_q <= 3'h4;
         end else if (busy_q) begin
            if (conv_done) begin
               busy_q <= 1'b0;
            end
            pace_q <= pace_q + 32'h00000001;
         end else if (first_q || pace_q >= pace_limit) begin
            // enables alone start the scan; no setup step needed [RULE22]
            conv_start_q <= 1'b1; // [RULE4]
            conv_input_q <= nxt; // [RULE5] [RULE6]
            cur_q <= nxt;
            busy_q <= 1'b1;
            // the start cycle is the first of the slot, so the next start
            // comes exactly pace_limit cycles later
            pace_q <= 32'h00000001; // [RULE13]
            first_q <= 1'b0;
         end else begin
            pace_q <= pace_q + 32'h00000001;
         end
      end
   end

   // result storage and status flags; a new result wins over the read clear of the result flag, a read wins for the overrun flag
   always @(posedge clk) begin
      if (!rstn) begin
         vdata_q <= 16'h0000;
         sf_q <= 1'b0;
         erf_q <= 1'b0;
         func_event_q <= 1'b0;
      end else begin
         func_event_q <= store; // [RULE9]
         if (store) begin
            vdata_q <= {clamped, 2'b00, cur_q, 2'b00}; // [RULE24] [RULE19]
            sf_q <= 1'b1; // [RULE9]
         end else if (rd_vdata) begin
            sf_q <= 1'b0; // [RULE10]
         end
         if (store && sf_q && !rd_vdata) begin
            erf_q <= 1'b1; // [RULE11]
         end else if (rd_vdata) begin
            erf_q <= 1'b0; // [RULE12]
         end
      end
   end

   // temperature readout latch: 10-bit value left aligned in bits 15-6 at half degree steps
   always @(posedge clk) begin
      if (!rstn) begin
         tdata_q <= 16'h0000;
      end else if (temp_done) begin
         tdata_q <= {temp_value, 2'b00, temp_sensor, (temp_fault && temp_sensor != 2'b00), 1'b0}; // [RULE23]
      end
   end

   // attention and enables toward the conversion front end
   always @(posedge clk) begin
      if (!rstn) begin
         attention_q <= 1'b0;
         temp_enables_q <= 3'h0;
      end else begin
         temp_enables_q <= tctrl_q[3:1]; // [RULE2]
         attention_q <= (store && vctrl_q[`TVSR_VCTRL_ATE]) // [RULE14]
            || (temp_done && tctrl_q[`TVSR_TCTRL_ATE] && |tctrl_q[3:1]); // [RULE1]
      end
   end

   // read mux; capabilities are constants, so resolution cannot be written
   always @(posedge clk) begin
      if (!rstn) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TVSR_ADDR_TEMP_DATA: reg_rdata_q <= tdata_q;
            `TVSR_ADDR_TEMP_CTRL: reg_rdata_q <= tctrl_q; // [RULE3]
            `TVSR_ADDR_VOLT_CAPS: reg_rdata_q <= `TVSR_VCAPS_VALUE; // [RULE17] [RULE19] [RULE20] [RULE21]
            `TVSR_ADDR_VOLT_DATA: reg_rdata_q <= vdata_q;
            `TVSR_ADDR_VOLT_CTRL: reg_rdata_q <= vctrl_q;
            `TVSR_ADDR_DEV_STATUS: reg_rdata_q <= {8'h00, `TVSR_FUNC_TYPE, 2'b00, erf_q, sf_q}; // [RULE18]
            default: reg_rdata_q <= 16'h0000;
         endcase
      end
   end
endmodule // tvsr_readout

// ===== sim/tvsr_front_model.sv
// tvsr_front_model.sv: analog front end stand-in answering conversion starts
// assumes: fed by conv_start_q of the readout block on the same clock
module tvsr_front_model (
   input wire clk,
   input wire start,
   output logic done,
   output logic [10:0] raw
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial begin
      done = 1'b0;
      raw = 11'h000;
   end
   always @(posedge clk) begin
      done <= 1'b0;
      // outside a result the lines flip every cycle, never a stale value
      raw <= ~raw;
      if (start) begin
         cnt <= 3;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            done <= 1'b1;
            raw <= 11'($urandom);
         end
      end
   end
endmodule // tvsr_front_model

// ===== sim/tvsr_readout_sva.sv
// tvsr_readout_sva.sv: port-level checks of the readout block
// assumes: bound into tvsr_readout, one clock, synchronous active-low reset
module tvsr_readout_sva (
   input wire clk,
   input wire rstn,
   input wire [5:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   input wire conv_done,
   input wire temp_done,
   input wire [15:0] reg_rdata_q,
   input wire conv_start_q,
   input wire [2:0] conv_input_q,
   input wire [2:0] temp_enables_q,
   input wire attention_q,
   input wire func_event_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   caps_fixed_a: assert property (
      reg_rd && reg_addr == 6'h10 |=> reg_rdata_q == 16'h0051) else $error("bad caps");
   tctrl_upper_a: assert property (
      reg_rd && reg_addr == 6'h0A |=> reg_rdata_q[15:4] == 12'h000) else $error("bad tctrl");
   tctrl_bits_a: assert property (
      reg_wr && reg_addr == 6'h0A |-> ##2 temp_enables_q == $past(reg_wdata[3:1], 2))
      else $error("bad temp enables");
   type_code_a: assert property (
      reg_rd && reg_addr == 6'h13 |=> reg_rdata_q[7:4] == 4'h2) else $error("bad type");
   readout_fmt_a: assert property (
      reg_rd && reg_addr == 6'h11 |=> reg_rdata_q[6:5] == 2'b00 && reg_rdata_q[1:0] == 2'b00
      && reg_rdata_q[4:2] <= 3'h4) else $error("bad readout");
   event_cause_a: assert property (
      $rose(func_event_q) |-> $past(conv_done) || $past(conv_done, 2)) else $error("bad event");
   attn_cause_a: assert property (
      attention_q |-> func_event_q || $past(temp_done) || $past(temp_done, 2))
      else $error("bad attention");
   start_range_a: assert property (
      conv_start_q |-> conv_input_q <= 3'h4 ##1 !conv_start_q) else $error("bad start");
endmodule // tvsr_readout_sva
bind tvsr_readout tvsr_readout_sva tvsr_readout_sva_inst (.clk(clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .conv_done(conv_done), .temp_done(temp_done), .reg_rdata_q(reg_rdata_q),
   .conv_start_q(conv_start_q), .conv_input_q(conv_input_q),
   .temp_enables_q(temp_enables_q), .attention_q(attention_q), .func_event_q(func_event_q));

// ===== sim/test_temp_voltage_scan_readout.sv
// test_temp_voltage_scan_readout.sv: random and corner tests of the readout block
// assumes: design, front end model and checker are compiled alongside
module test_temp_voltage_scan_readout;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SCAN = 50;
   localparam int SLOT = SCAN / 5;
   logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, low_power = 1'b0;
   logic temp_done = 1'b0, temp_fault = 1'b0, started = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, w;
   logic [1:0] temp_sensor = 2'h0;
   logic [9:0] temp_value = 10'h000;
   logic conv_done, conv_start_q, attention_q, func_event_q;
   logic [10:0] conv_raw, last_raw;
   logic [2:0] conv_input_q, temp_enables_q, last_in, prev_in;
   logic [4:0] mask = 5'h00;
   int n_fail = 0, n_checks = 0, cyc = 0, n_ev = 0, n_att = 0, n_conv = 0, n_st = 0;
   int t_st = 0, gap = 0;
   initial forever #25 clk = ~clk;
   tvsr_readout #(.SCAN_CYCLES(SCAN)) tvsr_readout_inst (.clk(clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .low_power(low_power), .conv_done(conv_done), .conv_raw(conv_raw),
      .temp_sensor(temp_sensor), .temp_done(temp_done), .temp_value(temp_value),
      .temp_fault(temp_fault), .reg_rdata_q(reg_rdata_q), .conv_start_q(conv_start_q),
      .conv_input_q(conv_input_q), .temp_enables_q(temp_enables_q),
      .attention_q(attention_q), .func_event_q(func_event_q));
   tvsr_front_model tvsr_front_model_inst (.clk(clk), .start(conv_start_q),
      .done(conv_done), .raw(conv_raw));
   function automatic logic [2:0] nxt(input logic [4:0] m, input logic [2:0] c);
      logic [2:0] k;
      k = c;
      for (int i = 0; i < 5; i++) begin
         k = (k == 3'h4) ? 3'h0 : k + 3'h1;
         if (m[k]) return k;
      end
      return c;
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e, input string s);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(s, e, reg_rdata_q);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_ev <= n_ev + func_event_q;
      n_att <= n_att + attention_q;
      if (conv_done && mask != 5'h00) begin
         n_conv <= n_conv + 1;
         last_raw <= conv_raw;
         last_in <= conv_input_q;
      end
      if (conv_start_q) begin
         n_st <= n_st + 1;
         chk("scan input", {13'h0, nxt(mask, started ? prev_in : 3'h4)}, {13'h0, conv_input_q});
         if (started) gap <= cyc - t_st;
         started <= 1'b1;
         prev_in <= conv_input_q;
         t_st <= cyc;
      end
      // generous ceiling, the whole run needs under 1500 cycles
      if (cyc > 3000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      int a, b, c;
      logic [4:0] m;
      logic ate;
      w = 16'($urandom(32'h58DA03A3));
      repeat (2) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      rd(6'h0A, 16'h0000, "temp ctrl reset");
      rd(6'h12, 16'h001F, "volt ctrl reset");
      rd(6'h3F, 16'h0000, "unmapped");
      wr(6'h10, 16'($urandom));
      rd(6'h10, 16'h0051, "caps");
      for (int k = 0; k < 5; k++) begin
         w = (k == 0) ? 16'($urandom) : {12'h000, 4'(k * 7 - 6)};
         wr(6'h0A, w);
         rd(6'h0A, w & 16'h000F, "temp ctrl");
         chk("temp enables", {13'h0, w[3:1]}, {13'h0, temp_enables_q});
         a = n_att;
         temp_sensor = 2'($urandom_range(2));
         temp_value = 10'($urandom);
         temp_fault = 1'($urandom);
         temp_done = 1'b1;
         @(negedge clk);
         temp_done = 1'b0;
         repeat (3) @(negedge clk);
         chk("temp attention", 16'(w[0] && w[3:1] != 3'h0), 16'(n_att - a));
         rd(6'h09, {temp_value, 2'b00, temp_sensor, temp_fault && temp_sensor != 2'h0, 1'b0}, "temp data");
      end
      repeat (3 * SLOT) @(negedge clk);
      chk("idle starts", 16'h0000, 16'(n_st));
      for (int r = 0; r < 4; r++) begin
         m = 5'($urandom_range(31, 1));
         ate = 1'($urandom);
         low_power = (r == 3);
         a = n_ev;
         b = n_att;
         c = n_conv;
         started = 1'b0;
         wr(6'h12, {5'h00, m, ate, 5'h00});
         mask = m;
         rd(6'h12, {5'h00, m, ate, 5'h1F}, "volt ctrl");
         repeat (SLOT * (r == 3 ? 16 : 6)) @(negedge clk);
         @(posedge conv_done);
         @(posedge clk);
         wr(6'h12, 16'h0000);
         mask = 5'h00;
         repeat (3) @(negedge clk);
         chk("scan gap", 16'(SLOT * (r == 3 ? 4 : 1)), 16'(gap));
         rd(6'h13, 16'h0023, "status set");
         rd(6'h11, {last_raw[10] ? 9'h000 : last_raw[9] ? 9'h1FF : last_raw[8:0], 2'b00, last_in, 2'b00}, "readout");
         rd(6'h13, 16'h0020, "status clear");
         chk("events", 16'(n_conv - c), 16'(n_ev - a));
         chk("attention", 16'(ate ? n_conv - c : 0), 16'(n_att - b));
      end
      test_done();
   end
endmodule // test_temp_voltage_scan_readout
